//--- design/ilo_addr_gen.sv
// Operand address generator for byte and bit oriented instructions
`timescale 1ns/100ps
module ilo_addr_gen
    import ilo_pkg::*;
(
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Configuration
    input wire logic ext_enable,
    // Bank select register load
    input wire logic bank_load,
    input wire logic [7:0] bank_wdata,
    // Stack frame pointer load
    input wire logic ptr_load,
    input wire logic [11:0] ptr_wdata,
    // Decoded operand
    input wire logic op_valid,
    input wire logic op_has_access,
    input wire logic [7:0] op_file,
    input wire logic op_access_sel,
    input wire logic op_dest,
    input wire logic op_is_ext,
    // Results
    output logic addr_valid,
    output logic [11:0] data_addr,
    output logic dest_to_file,
    output logic offset_used,
    output logic ext_insn_ok,
    output logic [7:0] bank_select_reg,
    output logic [11:0] stack_frame_pointer
);
    logic rst_s1_r;
    logic rst_s2_r;
    logic rst_n;
    logic take;
    ilo_mode_t mode_nxt;
    logic [11:0] addr_nxt;

    // Reset released through two flops so every register leaves reset on
    // the same edge; the synchroniser ignores clk_en so that a frozen core
    // still comes out of reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s2_r <= 1'b0;
        end else begin
            rst_s2_r <= rst_s1_r;
        end
    end

    assign rst_n = rst_s2_r;

    // Operand lies in the low, offset-capable part of the Access Bank
    function automatic logic is_short(
        input logic [7:0] f
    );
        is_short = (f <= OFFSET_LIMIT);
    endfunction

    // Operand in Access Bank: low part (up to OFFSET_LIMIT) from bank 0, rest from bank F
    function automatic logic [11:0] access_addr(
        input logic [7:0] f
    );
        if (is_short(f)) begin
            access_addr = {4'h0, f};
        end else begin
            access_addr = {ACCESS_HI_BANK, f};
        end
    endfunction

    // Banked operand; only the implemented bank field takes part
    function automatic logic [11:0] banked_addr(
        input logic [7:0] bank,
        input logic [7:0] f
    );
        banked_addr = {bank[BANK_MSB:BANK_LSB], f};
    endfunction

    // Pointer plus offset wraps at the data space top; the carry is
    // dropped rather than flagged, as a stack near FFFh is a user error
    function automatic logic [11:0] offset_addr(
        input logic [11:0] ptr,
        input logic [7:0] f
    );
        offset_addr = ADDR_W'(ptr + {4'h0, f});
    endfunction

    // One decode serves every byte and bit instruction with an a bit, so
    // no opcode can slip past the translation
    function automatic ilo_mode_t pick_mode(
        input logic ext,
        input logic a,
        input logic [7:0] f
    );
        if (!a && ext && is_short(f)) begin
            pick_mode = ILO_POINTER_OFFSET;
        end else if (!a) begin
            pick_mode = ILO_LITERAL_ACCESS;
        end else begin
            pick_mode = ILO_LITERAL_BANKED;
        end
    endfunction

    // Operand accepted on this edge
    function automatic logic op_taken(
        input logic en,
        input logic vld,
        input logic has_a
    );
        op_taken = en && vld && has_a;
    endfunction

    assign take = op_taken(clk_en, op_valid, op_has_access);

    // Bank select register; high nibble is never stored
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bank_select_reg <= BANK_RST;
        end else if (clk_en && bank_load) begin
            bank_select_reg <= {4'h0, bank_wdata[BANK_MSB:BANK_LSB]};
        end
    end

    // Stack frame pointer; a same-edge load is seen by the next operand
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stack_frame_pointer <= PTR_RST;
        end else if (clk_en && ptr_load) begin
            stack_frame_pointer <= ptr_wdata;
        end
    end

    always_comb begin
        mode_nxt = pick_mode(ext_enable, op_access_sel, op_file);
    end

    // Pointer zero yields exactly the Access RAM low-part address
    always_comb begin
        case (mode_nxt)
            ILO_POINTER_OFFSET: begin
                addr_nxt = offset_addr(stack_frame_pointer, op_file);
            end
            ILO_LITERAL_ACCESS: begin
                addr_nxt = access_addr(op_file);
            end
            ILO_LITERAL_BANKED: begin
                addr_nxt = banked_addr(bank_select_reg, op_file);
            end
            default: begin
                addr_nxt = ADDR_RST;
            end
        endcase
    end

    // Strobe per accepted operand, lasting one clk_en-enabled cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_valid <= 1'b0;
        end else if (clk_en) begin
            addr_valid <= take;
        end
    end

    // Address holds until the next accepted operand; 12 bits by type
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_addr <= ADDR_RST;
        end else if (take) begin
            data_addr <= addr_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            offset_used <= 1'b0;
        end else if (take) begin
            offset_used <= (mode_nxt == ILO_POINTER_OFFSET);
        end
    end

    // Destination bit passes through unaltered by the addressing mode
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dest_to_file <= 1'b0;
        end else if (take) begin
            dest_to_file <= op_dest;
        end
    end

    // Extended opcodes decode only under the same single enable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_insn_ok <= 1'b0;
        end else if (clk_en) begin
            ext_insn_ok <= op_valid && op_is_ext && ext_enable;
        end
    end

endmodule

//--- design/ilo_pkg.sv
// Package for the indexed literal offset operand address generator
package ilo_pkg;
    // Data space width and bounds
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_MAX = 12'hFFF;
    // Highest short operand that becomes a pointer offset
    localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
    // Access Bank: low part at bank 0, high part at bank F
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    // Bank field position within the bank select register
    localparam int BANK_LSB = 0;
    localparam int BANK_MSB = 3;
    // Reset values
    localparam logic [7:0] BANK_RST = 8'h00;
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic [11:0] ADDR_RST = 12'h000;
    // Number of extra instructions unlocked by the extension
    localparam int EXT_INSN_COUNT = 8;

    typedef enum logic [2:0] {
        ILO_LITERAL_ACCESS = 3'b001,
        ILO_LITERAL_BANKED = 3'b010,
        ILO_POINTER_OFFSET = 3'b100
    } ilo_mode_t;
endpackage

//--- tb/ilo_addr_gen_asserts.sv
// Port assertions for the operand address generator
`timescale 1ns/100ps
module ilo_addr_gen_asserts
    import ilo_pkg::*;
(
    input logic mclk, arst_n, clk_en, ext_enable, bank_load, op_valid,
    input logic op_has_access, op_access_sel, op_dest, op_is_ext,
    input logic addr_valid, dest_to_file, offset_used, ext_insn_ok,
    input logic [7:0] bank_wdata, op_file, bank_select_reg,
    input logic [11:0] data_addr, stack_frame_pointer
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire tk = clk_en & op_valid & op_has_access;
    wire lo = op_file <= OFFSET_LIMIT;
    sequence ofs_s;
        tk && !op_access_sel && ext_enable && lo;
    endsequence
    valid_pulse_a: assert property (clk_en |=> addr_valid == $past(tk))
        else $error("addr_valid wrong");
    ptr_offset_a: assert property (ofs_s |=> offset_used &&
        data_addr == 12'($past(stack_frame_pointer) + $past(op_file)))
        else $error("offset address wrong");
    bank_lit_a: assert property (tk && op_access_sel |=>
        !offset_used && data_addr == {$past(bank_select_reg[3:0]),
        $past(op_file)}) else $error("banked address wrong");
    access_lit_a: assert property (tk && !op_access_sel &&
        !(ext_enable && lo) |=> !offset_used && data_addr ==
        {$past(lo) ? 4'h0 : ACCESS_HI_BANK, $past(op_file)})
        else $error("access address wrong");
    dest_keep_a: assert property (tk |=> dest_to_file == $past(op_dest))
        else $error("destination wrong");
    bank_load_a: assert property (clk_en && bank_load |=>
        bank_select_reg == {4'h0, $past(bank_wdata[3:0])})
        else $error("bank load wrong");
    ext_ok_a: assert property (clk_en |=> ext_insn_ok ==
        $past(op_valid & op_is_ext & ext_enable)) else $error("ext wrong");
    bank_high_a: assert property (bank_select_reg[7:4] == 4'h0)
        else $error("bank high bits set");
endmodule
bind ilo_addr_gen ilo_addr_gen_asserts i_ilo_addr_gen_asserts (.*);

//--- tb/tb_indexed_literal_offset_addressing.sv
// Random bench comparing the address generator with a model
`timescale 1ns/100ps
module tb_indexed_literal_offset_addressing;
    import ilo_pkg::*;
    logic mclk = 0, arst_n = 0, clk_en = 0, ext_enable = 0, op_dest = 0;
    logic bank_load = 0, ptr_load = 0, op_valid = 0, op_has_access = 0;
    logic op_access_sel = 0, op_is_ext = 0, addr_valid, dest_to_file;
    logic offset_used, ext_insn_ok, tk, av = 0, xo = 0, eo = 0, ed = 0;
    logic [7:0] bank_wdata = 0, op_file = 0, bank_select_reg, bk = 0;
    logic [11:0] ptr_wdata = 0, data_addr, stack_frame_pointer, pt = 0;
    logic [11:0] ea = 0;
    logic [31:0] r;
    int seed = 41, error_cnt = 0, checked = 0;
    always #4 mclk = ~mclk;
    ilo_addr_gen i_ilo_addr_gen (.*);
    task automatic chk(string n, logic [20:0] x, logic [20:0] s);
        checked++;
        if (x !== s) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge mclk);
        arst_n = 1;
        repeat (2) @(posedge mclk);
        for (int i = 0; i < 3000; i++) begin
            @(negedge mclk);
            r = $random(seed);
            {ext_enable, op_access_sel, op_dest, op_is_ext} = r[3:0];
            {bank_load, ptr_load, bank_wdata, op_file} = r[21:4];
            {op_valid, op_has_access} = {|r[23:22], |r[25:24]};
            clk_en = |r[27:26];
            // Zero pointer often, to see the compatible mapping
            ptr_wdata = r[28] ? 12'h000 : r[31:20];
            tk = clk_en & op_valid & op_has_access;
            if (tk) begin
                ed = op_dest;
                eo = !op_access_sel && ext_enable && op_file <= OFFSET_LIMIT;
                ea = {op_file > OFFSET_LIMIT ? ACCESS_HI_BANK : 4'h0, op_file};
                if (op_access_sel) ea = {bk[3:0], op_file};
                if (eo) ea = pt + op_file;
            end
            if (clk_en) begin
                {av, xo} = {tk, op_valid & op_is_ext & ext_enable};
                if (bank_load) bk = {4'h0, bank_wdata[3:0]};
                if (ptr_load) pt = ptr_wdata;
            end
            @(posedge mclk);
            #1;
            chk("addr", {ea, eo}, {data_addr, offset_used});
            chk("ctl", {av, ed, xo}, {addr_valid, dest_to_file, ext_insn_ok});
            chk("regs", {bk, pt}, {bank_select_reg, stack_frame_pointer});
        end
        $display("random operand test done");
        stop_test();
    end
endmodule
